// ---- src/ddr_flash_params.svh ----
// constants for the ddr flash bus framing block
`ifndef DDR_FLASH_PARAMS_SVH
`define DDR_FLASH_PARAMS_SVH
`define PAGE_WORDS          5'h10
`define SUBPAGE_WORDS       5'h08
`define CMD_ADDR_BYTES      3'h6
`define CA_RW_BIT           47
`define CA_BURST_BIT        45
`define CA_ADDR_HI_BIT      44
`define CA_ADDR_LO_BIT      16
`define CA_ADDR_LOW3_BIT    0
`define LATENCY_RESET       5'h04
`endif

// ---- src/ddr_flash_pkg.sv ----
// types for the ddr flash bus framing block
package ddr_flash_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_LATENCY, ST_READ, ST_WRITE, ST_DONE} frame_state_t;
endpackage

// ---- src/word_fifo.sv ----
// valid/ready fifo with parameterised width and depth
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic [WIDTH-1:0]      o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} fifo_t;
	fifo_t state;
	fifo_t next_state;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;
	logic empty;
	always_comb begin
		empty = state.wr_ptr == state.rd_ptr;
		full = (state.wr_ptr[AW] != state.rd_ptr[AW]) && (state.wr_ptr[AW-1:0] == state.rd_ptr[AW-1:0]);
		o_ready = !full;
		o_valid = !empty;
		o_data = mem[state.rd_ptr[AW-1:0]];
		next_state = state;
		if (i_valid && !full) begin
			next_state.wr_ptr = state.wr_ptr + 1'b1;
		end
		if (i_ready && !empty) begin
			next_state.rd_ptr = state.rd_ptr + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_valid && !full) begin
			mem[state.wr_ptr[AW-1:0]] <= i_data;
		end
		if (i_reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule

// ---- src/ddr_flash_frame.sv ----
// device side framing of the ddr flash byte bus
`timescale 1ns/1ps
`include "ddr_flash_params.svh"
// Notes on behaviour
// [R1] add latency when linear read crosses page
// [R2] host starts frames with clock low
// [R3] host raises select between transactions
// [R4] device drives strobe during reads
// [R5] write opens with six command/address bytes
// [R6] burst-type bit ignored on writes
// [R7] write data: rising byte then falling
// [R8] select rising low-clock ends write anytime
// [R9] strobe held low through write frames
// [R10] host limits writes to one word
// [R11] complement clock optional, inverse when used
// [R12] host samples reads on strobe edges
module ddr_flash_frame #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic                    i_clk,
	input  wire logic                    i_reset,
	input  wire logic                    i_select_n,
	input  wire logic                    i_bus_clk,
	input  wire logic [7:0]              i_dq,
	output logic [7:0]                   o_dq,
	output logic                         o_dq_oe,
	output logic                         o_rw_data_strobe,
	output logic                         o_rw_data_strobe_oe,
	input  wire logic [4:0]              i_initial_latency_clocks,
	output logic [47:0]                  o_command_address_word,
	output logic                         o_command_valid,
	output logic [15:0]                  o_write_word,
	output logic                         o_write_valid,
	input  wire logic                    i_write_ready,
	input  wire logic [15:0]             i_read_word,
	input  wire logic                    i_read_valid,
	output logic                         o_read_ready
);
	import ddr_flash_pkg::*;
	localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;
	typedef logic [FILL_W-1:0] fill_cnt_t;
	typedef struct packed {
		ddr_flash_pkg::frame_state_t fsm;
		logic [1:0]  sel_sync;
		logic [1:0]  clk_sync;
		logic [7:0]  dq_s1;
		logic [7:0]  dq_s2;
		logic        clk_prev;
		logic [2:0]  byte_cnt;
		logic [47:0] ca;
		logic [5:0]  lat_cnt;
		logic        half;
		logic [7:0]  hi_byte;
		logic [15:0] rd_word;
		logic [7:0]  dq;
		logic        dq_oe;
		logic        strobe;
		logic        strobe_oe;
		logic        cmd_valid;
		logic [15:0] wr_word;
		logic        wr_valid;
		logic        rd_ready;
		fill_cnt_t   fill;
	} frame_t;
	frame_t state;
	frame_t next_state;
	logic [15:0] fifo_data;
	logic        fifo_valid;
	logic        fifo_pop;
	logic        fifo_push;
	logic        sel_active;
	logic        clk_rise;
	logic        clk_fall;
	logic        edge_any;
	logic [47:0] ca_next;

	function automatic logic [5:0] extra_latency(input logic [2:0] addr_low, input logic [4:0] initial_latency_clocks);
		logic [5:0] masked;
		logic [5:0] lim;
		masked = {3'h0, addr_low & 3'(`SUBPAGE_WORDS - 5'h01)};
		lim = 6'(`PAGE_WORDS) - {1'b0, initial_latency_clocks};
		if (initial_latency_clocks <= `PAGE_WORDS && lim < masked) begin
			extra_latency = 6'(masked - 6'(`PAGE_WORDS) + {1'b0, initial_latency_clocks}); // [R1]
		end else begin
			extra_latency = 6'h00;
		end
	endfunction

	word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_read_fifo (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_data  (i_read_word),
		.i_valid (fifo_push),
		.o_ready (),
		.o_data  (fifo_data),
		.o_valid (fifo_valid),
		.i_ready (fifo_pop)
	);

	always_comb begin
		next_state = state;
		sel_active = !state.sel_sync[1];
		clk_rise = state.clk_sync[1] && !state.clk_prev;
		clk_fall = !state.clk_sync[1] && state.clk_prev;
		edge_any = clk_rise || clk_fall;
		ca_next = {state.ca[39:0], state.dq_s2};
		fifo_pop = 1'b0;
		next_state.sel_sync = {state.sel_sync[0], i_select_n};
		next_state.clk_sync = {state.clk_sync[0], i_bus_clk};
		next_state.dq_s1 = i_dq;
		next_state.dq_s2 = state.dq_s1;
		next_state.clk_prev = state.clk_sync[1];
		next_state.cmd_valid = 1'b0;
		next_state.wr_valid = 1'b0;
		fifo_push = i_read_valid && state.rd_ready;
		if (!sel_active) begin
			// select high ends any frame, including a write cut short
			next_state.fsm = ST_IDLE; // [R8]
			next_state.dq_oe = 1'b0;
			next_state.strobe_oe = 1'b0;
			next_state.strobe = 1'b0;
			next_state.byte_cnt = 3'h0;
		end else begin
			unique case (state.fsm)
				ST_IDLE: begin
					// frame opens with clock low; first rising edge carries byte one
					next_state.fsm = ST_CMD; // [R2]
					next_state.byte_cnt = 3'h0;
					next_state.strobe = 1'b0;
					next_state.strobe_oe = 1'b1; // [R9]
				end
				ST_CMD: begin
					if (edge_any) begin
						next_state.ca = ca_next; // [R5]
						next_state.byte_cnt = state.byte_cnt + 3'h1;
						if (state.byte_cnt == `CMD_ADDR_BYTES - 3'h1) begin
							next_state.cmd_valid = 1'b1;
							next_state.half = 1'b0;
							if (ca_next[`CA_RW_BIT]) begin
								next_state.fsm = ST_LATENCY;
								next_state.lat_cnt = {1'b0, i_initial_latency_clocks} +
									(ca_next[`CA_BURST_BIT] ? 6'h00 :
									extra_latency(ca_next[2:0], i_initial_latency_clocks));
							end else begin
								// burst-type bit plays no part in writes
								next_state.fsm = ST_WRITE; // [R6]
							end
						end
					end
				end
				ST_LATENCY: begin
					next_state.strobe = 1'b0; // [R4]
					if (clk_rise) begin
						if (state.lat_cnt <= 6'h01) begin
							next_state.fsm = ST_READ;
						end else begin
							next_state.lat_cnt = state.lat_cnt - 6'h01;
						end
					end
				end
				ST_READ: begin
					if (clk_fall) begin
						next_state.dq_oe = 1'b1;
						if (!state.half) begin
							next_state.rd_word = fifo_data;
							next_state.dq = fifo_data[15:8];
							next_state.strobe = 1'b1; // [R4]
							fifo_pop = fifo_valid;
						end else begin
							next_state.dq = state.rd_word[7:0];
							next_state.strobe = 1'b0; // [R4]
						end
						next_state.half = !state.half;
					end
				end
				ST_WRITE: begin
					next_state.strobe = 1'b0; // [R9]
					if (edge_any) begin
						if (clk_rise) begin
							next_state.hi_byte = state.dq_s2; // [R7]
						end else if (i_write_ready) begin
							next_state.wr_word = {state.hi_byte, state.dq_s2}; // [R7]
							next_state.wr_valid = 1'b1;
						end
					end
				end
				ST_DONE: begin
					next_state.fsm = ST_IDLE;
				end
			endcase
		end
		// fill mirrors the read fifo so the registered ready never overpromises
		if (fifo_push && !fifo_pop) begin
			next_state.fill = state.fill + FILL_W'(1'h1);
		end else if (fifo_pop && !fifo_push) begin
			next_state.fill = state.fill - FILL_W'(1'h1);
		end
		next_state.rd_ready = next_state.fill < FILL_W'(FIFO_DEPTH);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= '0;
			state.fsm <= ST_IDLE;
			state.sel_sync <= 2'h3;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		o_dq = state.dq;
		o_dq_oe = state.dq_oe;
		o_rw_data_strobe = state.strobe;
		o_rw_data_strobe_oe = state.strobe_oe;
		o_command_address_word = state.ca;
		o_command_valid = state.cmd_valid;
		o_write_word = state.wr_word;
		o_write_valid = state.wr_valid;
		o_read_ready = state.rd_ready;
	end
endmodule

// ---- test/ddr_flash_host_model.sv ----
// host model driving the ddr flash byte bus
`timescale 1ns/1ps
module ddr_flash_host_model (
	output logic            o_select_n,
	output logic            o_bus_clk,
	output logic [7:0]      o_dq,
	input  wire logic       i_strobe,
	input  wire logic [7:0] i_dq
);
	logic [7:0] rd[$];
	initial {o_select_n, o_bus_clk, o_dq} = 10'h200;
	always @(i_strobe) begin
		#1;
		if (!o_select_n) rd.push_back(i_dq);
	end
	task frame(input logic [47:0] ca, input logic [15:0] wd, input int n);
		o_select_n = 0;
		for (int k = 0; k < n; k++) begin
			#16 o_dq = k < 6 ? ca[47 - 8 * k -: 8] : (k < 8 && !ca[47]) ? wd[63 - 8 * k -: 8] : ~o_dq;
			#16 o_bus_clk = ~o_bus_clk;
		end
		#16 o_select_n = 1;
		o_dq = ~o_dq;
		#32;
	endtask
endmodule

// ---- test/ddr_flash_frame_asserts.sv ----
// assertion checker for the ddr flash framing block
`timescale 1ns/1ps
module ddr_flash_frame_asserts (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        i_select_n,
	input wire logic        o_dq_oe,
	input wire logic        o_rw_data_strobe,
	input wire logic        o_rw_data_strobe_oe,
	input wire logic [47:0] o_command_address_word,
	input wire logic        o_command_valid,
	input wire logic        o_write_valid
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence wr_cmd;
		o_command_valid && !o_command_address_word[47];
	endsequence
	strobe_low_a: assert property (wr_cmd |-> !o_rw_data_strobe [*8])
		else $error("strobe high in write");
	write_no_drive_a: assert property (wr_cmd |-> !o_dq_oe [*8])
		else $error("bus driven in write");
	end_release_a: assert property ($rose(i_select_n) |-> ##[1:5] !o_rw_data_strobe_oe)
		else $error("strobe kept after select");
	idle_quiet_a: assert property (i_select_n [*6] |-> !o_rw_data_strobe_oe && !o_dq_oe)
		else $error("driving while idle");
	read_strobe_a: assert property (o_dq_oe |-> o_rw_data_strobe_oe)
		else $error("read without strobe");
	strobe_moves_a: assert property ($changed(o_rw_data_strobe) && o_rw_data_strobe_oe |-> o_dq_oe)
		else $error("strobe moved outside read");
	cmd_pulse_a: assert property (o_command_valid |=> !o_command_valid)
		else $error("command pulse long");
	write_pulse_a: assert property (o_write_valid |=> !o_write_valid)
		else $error("write pulse long");
	cover property (wr_cmd);
	cover property (o_dq_oe);
	cover property (o_write_valid);
endmodule
bind ddr_flash_frame ddr_flash_frame_asserts i_ddr_flash_frame_asserts (.i_clk(i_clk), .i_reset(i_reset),
	.i_select_n(i_select_n), .o_dq_oe(o_dq_oe), .o_rw_data_strobe(o_rw_data_strobe),
	.o_rw_data_strobe_oe(o_rw_data_strobe_oe), .o_command_address_word(o_command_address_word),
	.o_command_valid(o_command_valid), .o_write_valid(o_write_valid));

// ---- test/ddr_flash_frame_bench.sv ----
// self-checking bench for the ddr flash framing block
`timescale 1ns/1ps
module ddr_flash_frame_bench;
	import ddr_flash_pkg::*;
	logic        clk = 0, rst = 1, sel_n, bclk, rd_v = 0, dq_oe, strb, strb_oe, cv, wv, rd_rdy, wr_rdy = 1;
	logic [7:0]  dq_h, dq_d;
	logic [4:0]  lat = 5'h0C;
	logic [15:0] rw = 16'h0000, ww;
	logic [47:0] ca_o;
	logic [15:0] wq[$], fq[$];
	int          failures = 0, compares = 0;
	always #2.5 clk = ~clk;
	ddr_flash_frame i_ddr_flash_frame (.i_clk(clk), .i_reset(rst), .i_select_n(sel_n), .i_bus_clk(bclk),
		.i_dq(dq_h), .o_dq(dq_d), .o_dq_oe(dq_oe), .o_rw_data_strobe(strb), .o_rw_data_strobe_oe(strb_oe),
		.i_initial_latency_clocks(lat), .o_command_address_word(ca_o), .o_command_valid(cv), .o_write_word(ww),
		.o_write_valid(wv), .i_write_ready(wr_rdy), .i_read_word(rw), .i_read_valid(rd_v), .o_read_ready(rd_rdy));
	ddr_flash_host_model i_ddr_flash_host_model (.o_select_n(sel_n), .o_bus_clk(bclk), .o_dq(dq_h),
		.i_strobe(strb), .i_dq(dq_d));
	always @(negedge clk) if (wv) wq.push_back(ww);
	task chk(input logic [47:0] got, input logic [47:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	function int xlat(int l, int a);
		return (16 - l < a) ? a - 16 + l : 0;
	endfunction
	initial begin
		#200000;
		failures++;
		stop_test;
	end
	initial begin
		logic [47:0] ca;
		logic [15:0] d;
		void'($urandom(32'h8FF2));
		repeat (8) @(negedge clk);
		rst = 0;
		repeat (17) begin
			@(negedge clk);
			rw = 16'($urandom);
			rd_v = 1;
			if (rd_rdy) fq.push_back(rw);
		end
		@(negedge clk) rd_v = 0;
		chk(rd_rdy, 0);
		chk(fq.size(), 16);
		$display("fill test done");
		for (int i = 0; i < 5; i++) begin
			ca = {1'b0, 15'($urandom), 32'($urandom)};
			ca[45] = i[0];
			d = 16'($urandom);
			@(negedge clk) wr_rdy = i != 3;
			i_ddr_flash_host_model.frame(ca, d, i == 4 ? 6 : 8);
			chk(ca_o, ca);
			if (i < 3) chk(wq.pop_front(), d);
			else chk(wq.size(), 0);
		end
		$display("write test done");
		for (int i = 0; i < 8; i++) begin
			@(negedge clk) lat = 5'($urandom_range(15, 10));
			ca = {3'b100, 13'($urandom), 32'($urandom)};
			ca[45] = i == 3;
			ca[2:0] = i == 0 || i == 3 ? 3'h7 : 3'($urandom);
			i_ddr_flash_host_model.rd.delete();
			i_ddr_flash_host_model.frame(ca, 16'h0000, 6 + 2 * (lat + (ca[45] ? 0 : xlat(lat, ca[2:0])) - 1) + 8);
			chk(i_ddr_flash_host_model.rd.size(), 4);
			repeat (2) begin
				d = fq.pop_front();
				chk(i_ddr_flash_host_model.rd.pop_front(), d[15:8]);
				chk(i_ddr_flash_host_model.rd.pop_front(), d[7:0]);
			end
		end
		chk(rd_rdy, 1);
		$display("read test done");
		stop_test;
	end
endmodule
